// ===== fdpm_consts.svh
// Constants for the flexible data port multiplexer
`ifndef FDPM_CONSTS_SVH
`define FDPM_CONSTS_SVH

// Data bus geometry
`define FDPM_MSB         9
`define FDPM_ALL_ONES    10'h3FF
`define FDPM_MSB_MASK    10'h200
`define FDPM_ZERO        10'h000

// Pin synchroniser width: link clock, fd strap, direction_or_marker_pin, width_or_sysclk_pin, upper, lower
`define FDPM_SYNC_W      24

// Strap capture waits for the synchroniser to fill after reset release
`define FDPM_STRAP_WAIT  2'h2
`define FDPM_CNT_ONE     2'h1

// Register map: word index taken from address bits 3:2
`define FDPM_ADDR_W      4
`define FDPM_CTRL_IDX    2'h0
`define FDPM_STAT_IDX    2'h1
`define FDPM_CTRL_RST    4'h0
`define FDPM_RESP_OKAY   2'h0
`define FDPM_RESP_SLVERR 2'h2

`endif

// ===== fdpm_pkg.sv
// Types shared by the flexible data port multiplexer
package fdpm_pkg;

  typedef enum logic [1:0] {
    parallel_half_duplex_mode    = 2'b00,
    interleaved_half_duplex_mode = 2'b01,
    full_duplex_mode             = 2'b10,
    legacy_compat_mode           = 2'b11
  } fdpm_mode_type;

  // Control register layout, most significant field first
  typedef struct packed {
    logic          hd_sysclk_en;
    fdpm_mode_type mode;
    logic          serial_cfg;
  } fdpm_ctrl_type;

  // Status register layout, most significant field first
  typedef struct packed {
    logic          strap_width_hi;
    logic          strap_fd;
    logic          tx_dir;
    fdpm_mode_type mode;
  } fdpm_status_type;

  // Synchronised pin group
  typedef struct packed {
    logic       conv_clk;
    logic       fd_pin;
    logic       dir_pin;
    logic       width_pin;
    logic [9:0] upper;
    logic [9:0] lower;
  } fdpm_pins_type;

endpackage : fdpm_pkg

// ===== fdpm_sync.sv
// Two-stage synchroniser for all pins entering the mclk domain
`timescale 1ns/10ps
`include "fdpm_consts.svh"
module fdpm_sync import fdpm_pkg::*; (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [`FDPM_SYNC_W-1:0]   async_in,
  output fdpm_pins_type                  sync_out
);

  logic [`FDPM_SYNC_W-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : fdpm_sync

// ===== fdpm_axil.sv
// AXI4-Lite slave holding the control register and reading status
`timescale 1ns/10ps
`include "fdpm_consts.svh"
module fdpm_axil import fdpm_pkg::*; (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [`FDPM_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`FDPM_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  fdpm_status_type               status,
  output fdpm_ctrl_type                 ctrl
);

  logic [1:0] aw_idx;
  logic [7:0] w_byte;
  logic       w_lane0;

  // Address and data are taken in either order; ready drops until the response
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FDPM_RESP_OKAY;
      aw_idx        <= '0;
      w_byte        <= '0;
      w_lane0       <= 1'b0;
      ctrl          <= `FDPM_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx        <= s_axi_awaddr[3:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_idx == `FDPM_CTRL_IDX) begin
          s_axi_bresp <= `FDPM_RESP_OKAY;
          if (w_lane0) begin
            ctrl <= fdpm_ctrl_type'(w_byte[3:0]);
          end
        end else if (aw_idx == `FDPM_STAT_IDX) begin
          s_axi_bresp <= `FDPM_RESP_OKAY;  // Status ignores writes
        end else begin
          s_axi_bresp <= `FDPM_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `FDPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `FDPM_RESP_OKAY;
      unique case (s_axi_araddr[3:2])
        `FDPM_CTRL_IDX: s_axi_rdata <= 32'(ctrl);
        `FDPM_STAT_IDX: s_axi_rdata <= 32'(status);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `FDPM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : fdpm_axil

// ===== fdpm_top.sv
// Flexible data port multiplexer: steers two-channel samples over two 10-bit buses
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "fdpm_consts.svh"
module fdpm_top import fdpm_pkg::*; (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [`FDPM_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`FDPM_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     conv_clk,
  input  wire logic                     mode_fd_pin,
  input  wire logic [9:0]               upper_data_bus_in,
  output logic [9:0]                    upper_data_bus_out,
  output logic [9:0]                    upper_data_bus_oe,
  input  wire logic [9:0]               lower_data_bus_in,
  output logic [9:0]                    lower_data_bus_out,
  output logic [9:0]                    lower_data_bus_oe,
  input  wire logic                     direction_or_marker_pin,
  input  wire logic                     width_or_sysclk_pin_in,
  output logic                          width_or_sysclk_pin_out,
  output logic                          width_or_sysclk_pin_oe,
  output logic                          data_clock_out_pin,
  input  wire logic [9:0]               rx_a_sample,
  input  wire logic [9:0]               rx_b_sample,
  output logic                          rx_taken,
  output logic [9:0]                    tx_a_sample,
  output logic [9:0]                    tx_b_sample,
  output logic                          tx_valid
);

  fdpm_pins_type   pins;
  fdpm_ctrl_type   ctrl;
  fdpm_status_type status;
  fdpm_mode_type   cur_mode;
  fdpm_mode_type   next_mode;

  logic       conv_d;
  logic       conv_rise;
  logic       conv_fall;
  logic [1:0] strap_cnt;
  logic       strap_done;
  logic       strap_fd;
  logic       strap_width_hi;
  logic       tx_dir;
  logic       rx_active;
  logic       tx_active;
  logic       interleaved;
  logic       rx_interleaved;
  logic       tx_marker;
  logic       rx_marker;
  logic [9:0] rx_b_hold;
  logic [9:0] tx_a_hold;
  logic       word_edge;
  logic       word_edge_q;

  // All pins and the link clock cross into mclk through two flops
  fdpm_sync u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({conv_clk, mode_fd_pin, direction_or_marker_pin,
                width_or_sysclk_pin_in, upper_data_bus_in, lower_data_bus_in}),
    .sync_out (pins)
  );

  fdpm_axil u_axil (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status        (status),
    .ctrl          (ctrl)
  );

  // Link clock edges seen from mclk; conv_d follows the second sync stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_d <= 1'b0;
    end else begin
      conv_d <= pins.conv_clk;
    end
  end

  assign conv_rise = pins.conv_clk & ~conv_d;
  assign conv_fall = ~pins.conv_clk & conv_d;

  // Straps wait until the synchroniser holds real pin levels, then freeze
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt      <= '0;
      strap_done     <= 1'b0;
      strap_fd       <= 1'b0;
      strap_width_hi <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == `FDPM_STRAP_WAIT) begin
        strap_fd       <= pins.fd_pin;
        strap_width_hi <= pins.width_pin;
        strap_done     <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + `FDPM_CNT_ONE;
      end
    end
  end

  // Pins choose among three modes; legacy exists only through the register
  always_comb begin
    if (ctrl.serial_cfg) begin
      next_mode = ctrl.mode;
    end else if (strap_fd) begin
      next_mode = full_duplex_mode;
    end else if (strap_width_hi) begin
      next_mode = interleaved_half_duplex_mode;
    end else begin
      next_mode = parallel_half_duplex_mode;
    end
  end

  // Mode and direction are registered so one decision governs a whole cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_mode <= parallel_half_duplex_mode;
      tx_dir   <= 1'b0;
    end else begin
      cur_mode <= next_mode;
      tx_dir   <= pins.dir_pin;
    end
  end

  // Only full duplex runs both paths; half duplex follows the direction pin
  assign rx_active      = (cur_mode == full_duplex_mode) | ~tx_dir;
  assign tx_active      = (cur_mode == full_duplex_mode) | tx_dir;
  assign interleaved    = (cur_mode != parallel_half_duplex_mode);
  assign rx_interleaved = (cur_mode == interleaved_half_duplex_mode) |
                          (cur_mode == full_duplex_mode);
  // Full duplex marker arrives on pin1, otherwise on the lower bus MSB
  assign tx_marker      = (cur_mode == full_duplex_mode) ? pins.dir_pin
                                                         : pins.lower[`FDPM_MSB];
  assign word_edge      = (rx_active | tx_active) &
                          (conv_rise | (conv_fall & (interleaved | rx_interleaved)));

  // Receive launch: parallel on the link rise, interleaved on both edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_data_bus_out <= '0;
      lower_data_bus_out <= '0;
      rx_b_hold          <= '0;
      rx_marker          <= 1'b0;
      rx_taken           <= 1'b0;
    end else begin
      rx_taken <= 1'b0;
      if (rx_active && conv_rise) begin
        rx_taken  <= 1'b1;
        rx_b_hold <= rx_b_sample;
        if (rx_interleaved) begin
          lower_data_bus_out <= rx_a_sample;
          rx_marker          <= 1'b0;
          upper_data_bus_out <= `FDPM_ZERO;
        end else begin
          upper_data_bus_out <= rx_b_sample;
          lower_data_bus_out <= rx_a_sample;
        end
      end else if (rx_active && conv_fall && rx_interleaved) begin
        lower_data_bus_out <= rx_b_hold;
        rx_marker          <= 1'b1;
        upper_data_bus_out <= `FDPM_MSB_MASK;
      end
    end
  end

  // Drive enables: the bus a path does not use floats, markers excepted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_data_bus_oe <= `FDPM_ZERO;
      lower_data_bus_oe <= `FDPM_ZERO;
    end else if (cur_mode == full_duplex_mode) begin
      upper_data_bus_oe <= `FDPM_ZERO;
      lower_data_bus_oe <= `FDPM_ALL_ONES;
    end else if (tx_dir) begin
      // The partner drives both buses, lower MSB as its marker when interleaved, so nothing is driven
      upper_data_bus_oe <= `FDPM_ZERO;
      lower_data_bus_oe <= `FDPM_ZERO;
    end else begin
      upper_data_bus_oe <= (cur_mode == interleaved_half_duplex_mode) ?
                           `FDPM_MSB_MASK : `FDPM_ALL_ONES;
      lower_data_bus_oe <= `FDPM_ALL_ONES;
    end
  end

  // Transmit capture: pairs assemble before one valid pulse reaches the DACs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_a_sample <= '0;
      tx_b_sample <= '0;
      tx_a_hold   <= '0;
      tx_valid    <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      if (tx_active && !interleaved && conv_rise) begin
        tx_a_sample <= pins.upper;
        tx_b_sample <= pins.lower;
        tx_valid    <= 1'b1;
      end else if (tx_active && interleaved && (conv_rise || conv_fall)) begin
        if (tx_marker) begin
          tx_a_hold <= pins.upper;
        end else begin
          tx_a_sample <= tx_a_hold;
          tx_b_sample <= pins.upper;
          tx_valid    <= 1'b1;
        end
      end
    end
  end

  // Data clock pulses one cycle after each word so data is settled first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_edge_q        <= 1'b0;
      data_clock_out_pin <= 1'b0;
    end else begin
      word_edge_q        <= word_edge;
      data_clock_out_pin <= word_edge_q;
    end
  end

  // Pin2 is an input until straps are taken; afterwards it may become a clock or, in pin full duplex, the receive marker output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      width_or_sysclk_pin_out <= 1'b0;
      width_or_sysclk_pin_oe  <= 1'b0;
    end else if (!strap_done) begin
      width_or_sysclk_pin_oe <= 1'b0;
    end else if (ctrl.serial_cfg &&
                 (cur_mode == full_duplex_mode || ctrl.hd_sysclk_en)) begin
      width_or_sysclk_pin_out <= pins.conv_clk;
      width_or_sysclk_pin_oe  <= 1'b1;
    end else if (!ctrl.serial_cfg && cur_mode == full_duplex_mode) begin
      width_or_sysclk_pin_out <= rx_marker;
      width_or_sysclk_pin_oe  <= 1'b1;
    end else begin
      width_or_sysclk_pin_oe <= 1'b0;
    end
  end

  assign status = '{strap_width_hi: strap_width_hi, strap_fd: strap_fd,
                    tx_dir: tx_dir, mode: cur_mode};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_PAR_RX: assert property (
    (rx_active && conv_rise && cur_mode == parallel_half_duplex_mode) |=>
      (upper_data_bus_out == $past(rx_b_sample) &&
       lower_data_bus_out == $past(rx_a_sample)))
    else $error("parallel receive words misplaced");
  AST_ILV_RX_A: assert property (
    (rx_active && conv_rise && rx_interleaved) |=>
      (!rx_marker && lower_data_bus_out == $past(rx_a_sample)))
    else $error("interleaved receive channel A missing");
  AST_ILV_RX_B: assert property (
    (rx_active && conv_rise && rx_interleaved) ##4 (conv_fall && rx_active && rx_interleaved)
      |=> (rx_marker && lower_data_bus_out == $past(rx_b_sample, 5)))
    else $error("interleaved receive channel B missing");
  AST_TX_PAR: assert property (
    (tx_active && !interleaved && conv_rise) |=>
      (tx_valid && tx_a_sample == $past(pins.upper) && tx_b_sample == $past(pins.lower)))
    else $error("parallel transmit capture wrong");
  AST_TX_ILV: assert property (
    (tx_active && interleaved && (conv_rise || conv_fall) && !tx_marker) |=>
      (tx_valid && tx_b_sample == $past(pins.upper)))
    else $error("interleaved transmit pair wrong");
  AST_PIN_MODE: assert property (
    (strap_done && !ctrl.serial_cfg && !strap_fd) |=>
      (cur_mode == (strap_width_hi ? interleaved_half_duplex_mode
                                   : parallel_half_duplex_mode)))
    else $error("pin mode decode wrong");
  AST_NO_LEGACY_PINS: assert property (
    !ctrl.serial_cfg |=> (cur_mode != legacy_compat_mode))
    else $error("legacy mode reached by pins");
  AST_ILV_OE: assert property (
    (cur_mode == interleaved_half_duplex_mode && !tx_dir) [*2] |->
      (upper_data_bus_oe == `FDPM_MSB_MASK))
    else $error("interleaved receive upper bus not floated");
  AST_FD_BUS: assert property (
    (cur_mode == full_duplex_mode) [*2] |->
      (upper_data_bus_oe == `FDPM_ZERO && lower_data_bus_oe == `FDPM_ALL_ONES))
    else $error("full duplex bus roles wrong");
  AST_HD_TX_FLOAT: assert property (
    (cur_mode != full_duplex_mode && tx_dir) [*2] |->
      (upper_data_bus_oe == `FDPM_ZERO && lower_data_bus_oe == `FDPM_ZERO))
    else $error("bus driven during half duplex transmit");
  AST_SYSCLK: assert property (
    (strap_done && ctrl.serial_cfg && cur_mode == full_duplex_mode) [*2] |->
      width_or_sysclk_pin_oe)
    else $error("system clock not driven on pin2");
  AST_CLK_OUT: assert property (
    word_edge |-> ##2 data_clock_out_pin)
    else $error("data clock pulse missing");
  AST_STRAP: assert property (
    (!strap_done && strap_cnt == `FDPM_STRAP_WAIT) |=>
      (strap_done && strap_fd == $past(pins.fd_pin)))
    else $error("strap not captured");

endmodule : fdpm_top

// ===== fdpm_partner.sv
// Baseband processor model: launches transmit words and the marker pin
`timescale 1ns/10ps
module fdpm_partner (
  input  wire logic       mclk,
  input  wire logic       conv_clk,
  input  wire logic       tx_on,
  input  wire logic       il,
  input  wire logic       fd,
  input  wire logic [9:0] tx_a,
  input  wire logic [9:0] tx_b,
  output logic      [9:0] upper,
  output logic      [9:0] lower,
  output logic            pin1
);
  logic [9:0] junk;
  // Released lines toggle each cycle so a stale value never passes for data
  always @(posedge mclk) junk <= (junk === 10'h0AA) ? 10'h355 : 10'h0AA;
  // Words change with the link clock edges, A while it is high
  always_comb begin
    pin1  = fd ? conv_clk : tx_on;
    upper = !tx_on ? junk : (!il || conv_clk) ? tx_a : tx_b;
    lower = (!tx_on || fd) ? junk : !il ? tx_b : {conv_clk, junk[8:0]};
  end
endmodule : fdpm_partner

// ===== flexible_data_port_mux_test.sv
// Self-checking bench for the flexible data port multiplexer
`timescale 1ns/10ps
module flexible_data_port_mux_test;
  import fdpm_pkg::*;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [9:0] uoe;
    logic [9:0] ubus;
    logic       woe;
    logic       rxil;
    logic       txil;
  } fdpm_row_type;
  localparam logic [9:0] RA = 10'h3C1;
  localparam logic [9:0] RB = 10'h24E;
  localparam logic [9:0] TA = 10'h1B7;
  localparam logic [9:0] TB = 10'h0E2;
  logic mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic conv_clk, mode_fd_pin, direction_or_marker_pin, width_or_sysclk_pin_in;
  logic width_or_sysclk_pin_out, width_or_sysclk_pin_oe, data_clock_out_pin;
  logic rx_taken, tx_valid, tx_on, txil, fd, w_strap;
  logic [9:0] upper_data_bus_in, upper_data_bus_out, upper_data_bus_oe, p_up, p_lo;
  logic [9:0] lower_data_bus_in, lower_data_bus_out, lower_data_bus_oe;
  logic [9:0] rx_a_sample, rx_b_sample, tx_a_sample, tx_b_sample;
  int fail_count = 0;
  int checked = 0;
  fdpm_row_type rw;
  fdpm_row_type rows [4] = '{'{4'h1, 10'h3FF, RB, 1'b0, 1'b0, 1'b0},
    '{4'h3, 10'h200, 10'h000, 1'b0, 1'b1, 1'b1}, '{4'h5, 10'h000, 10'h000, 1'b1, 1'b1, 1'b1},
    '{4'h7, 10'h3FF, RB, 1'b0, 1'b0, 1'b1}};

  // Wire levels from every party's enables
  assign upper_data_bus_in = (upper_data_bus_oe & upper_data_bus_out) | (~upper_data_bus_oe & p_up);
  assign lower_data_bus_in = (lower_data_bus_oe & lower_data_bus_out) | (~lower_data_bus_oe & p_lo);
  assign width_or_sysclk_pin_in = width_or_sysclk_pin_oe ? width_or_sysclk_pin_out : w_strap;

  fdpm_top fdpm_top_inst (.*);
  fdpm_partner fdpm_partner_inst (.mclk(mclk), .conv_clk(conv_clk), .tx_on(tx_on), .il(txil),
    .fd(fd), .tx_a(TA), .tx_b(TB), .upper(p_up), .lower(p_lo), .pin1(direction_or_marker_pin));

  // System clock and a free-running link clock of unrelated phase
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    conv_clk = 1'b0;
    #37;
    forever #400 conv_clk = ~conv_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  // Bounded wait for a receive take or a transmit pair
  task automatic wait_pulse(input bit tx);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while ((tx ? tx_valid : rx_taken) !== 1'b1 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1);
  endtask : wait_pulse

  task automatic tally_and_finish;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Watchdog: the whole run needs well under 3000 cycles
  initial begin
    repeat (8000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence: straps, row loop over modes, then a full duplex strap reset
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    {rst_n, mode_fd_pin, tx_on, txil, fd, w_strap} = 6'h01;
    rx_a_sample = RA;
    rx_b_sample = RB;
    repeat (8) @(posedge mclk);
    chk(32'({upper_data_bus_oe, lower_data_bus_oe, width_or_sysclk_pin_oe}), 32'h0);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(4'h4);
    chk(d, 32'h11);
    rd(4'h0);
    chk(d, 32'h0);
    rd(4'h8);
    chk(32'({d, r}), 32'h2);
    for (int i = 0; i < 4; i++) begin
      rw = rows[i];
      tx_on <= 1'b0;
      txil <= rw.txil;
      fd <= (rw.ctrl === 4'h5);
      wr(4'h0, 32'(rw.ctrl));
      chk(32'(r), 32'h0);
      wait_pulse(0);
      wait_pulse(0);
      chk(32'(upper_data_bus_out & upper_data_bus_oe), 32'(rw.ubus));
      chk(32'(upper_data_bus_oe), 32'(rw.uoe));
      chk(32'(lower_data_bus_out), 32'(RA));
      chk(32'(width_or_sysclk_pin_oe), 32'(rw.woe));
      // Clock pulse stands one cycle after the word; the fall word lands four edges after rise
      repeat (1) @(posedge mclk);
      #1 chk(32'(data_clock_out_pin), 32'h1);
      repeat (3) @(posedge mclk);
      #1;
      if (rw.rxil) begin
        chk(32'(lower_data_bus_out), 32'(RB));
        chk(32'(upper_data_bus_out & upper_data_bus_oe), 32'(rw.uoe & 10'h200));
      end
      tx_on <= 1'b1;
      wait_pulse(1);
      wait_pulse(1);
      chk(32'({tx_a_sample, tx_b_sample}), 32'({TA, TB}));
      chk(32'(lower_data_bus_oe), fd ? 32'h3FF : 32'h0);
    end
    rst_n <= 1'b0;
    mode_fd_pin <= 1'b1;
    w_strap <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(4'h4);
    chk(d & 32'h1B, 32'h0A);
    chk(32'(width_or_sysclk_pin_oe), 32'h1);
    // Pin full duplex: pin2 shows the channel A marker level one cycle after a rise
    wait_pulse(0);
    @(posedge mclk);
    #1 chk(32'(width_or_sysclk_pin_out), 32'h0);
    tally_and_finish();
  end
endmodule : flexible_data_port_mux_test
